/* design/uamp_device.sv */
// Device end: register-driven transmitter and receiver with multiprocessor addressing.
// Assumes a single clk domain; the peer line is asynchronous and is synchronised here.
`timescale 1ns/10ps
module uamp_device #(
   parameter int BAUD_HALF = uamp_pkg::BAUD_HALF_DEF
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Serial link
   uamp_link_if.dev link,
   // Register port
   input wire logic [uamp_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Event requests
   output logic tx_request,
   output logic rx_request
);
   import uamp_pkg::*;

   // ------------------------------------------------
   // Declarations
   // ------------------------------------------------
   logic [7:0] div_cnt; // Baud divider
   logic baud_q; // Baud clock level
   logic rise_tick, fall_tick; // Baud edges
   logic [7:0] comm_control_reg; // Frame and mode config
   logic tx_wake_flag, tx_action_enable, sleep_en;
   logic [7:0] tx_data_buffer; // Pending character
   logic tx_full; // Buffer holds a character
   logic tx_load; // Buffer to shifter move
   uamp_state_type tx_state;
   logic [FRAME_W-1:0] tx_shift_register; // Bits still to send
   logic [3:0] tx_bits; // Bits left
   logic [2:0] tx_sub; // Baud period within bit
   logic tx_line; // Driven line level
   logic rx_s1, rx_s2; // Line synchroniser
   uamp_state_type rx_state;
   logic [FRAME_W-1:0] rx_shift_register; // Received bits
   logic [3:0] rx_idx; // Next bit index
   logic [2:0] rx_sub; // Sample within bit
   logic [2:0] vote; // Majority samples
   logic [3:0] idle_bits; // Saturating idle count
   logic [2:0] idle_sub;
   logic gap_ok; // Gap before this frame was long
   logic [7:0] rx_data_buffer;
   logic rx_wake_flag, rx_ready;
   logic bit_end, rx_val, rx_abort, rx_done, rx_is_addr, rx_deliver;
   logic [2:0] lm1;
   logic pe, po, am, iso, ts;

   assign lm1 = comm_control_reg[CCR_LEN_LSB +: 3];
   assign am = comm_control_reg[CCR_ADDR_MODE]; // R2
   assign iso = comm_control_reg[CCR_ISO];
   assign pe = comm_control_reg[CCR_PAR_EN];
   assign po = comm_control_reg[CCR_PAR_ODD];
   assign ts = comm_control_reg[CCR_TWO_STOP];

   // ------------------------------------------------
   // Baud clock
   // ------------------------------------------------
   // Divider toggles the baud clock; edges mark tx and rx moments
   always_ff @(posedge clk) begin
      if (!rstn) begin
         div_cnt <= 8'h00;
         baud_q <= 1'b0;
      end else if (div_cnt == 8'(BAUD_HALF - 1)) begin
         div_cnt <= 8'h00;
         baud_q <= ~baud_q;
      end else begin
         div_cnt <= div_cnt + 8'h01;
      end
   end
   assign rise_tick = (div_cnt == 8'(BAUD_HALF - 1)) && !baud_q;
   assign fall_tick = (div_cnt == 8'(BAUD_HALF - 1)) && baud_q;
   assign link.baud_clk = baud_q;

   // ------------------------------------------------
   // Registers
   // ------------------------------------------------
   // Software configuration
   always_ff @(posedge clk) begin
      if (!rstn) begin
         comm_control_reg <= CCR_RST;
         tx_action_enable <= 1'b0;
         sleep_en <= 1'b0;
      end else if (reg_wr) begin
         if (reg_addr == OFF_COMM) begin
            comm_control_reg <= reg_wdata[7:0];
         end
         if (reg_addr == OFF_TXCTL) begin
            tx_action_enable <= reg_wdata[ENA_BIT];
         end
         if (reg_addr == OFF_RXCTL) begin
            sleep_en <= reg_wdata[ENA_BIT];
         end
      end
   end

   // Wake flag: a fresh software write beats the hardware clear
   always_ff @(posedge clk) begin
      if (!rstn) begin
         tx_wake_flag <= 1'b0;
      end else if (reg_wr && reg_addr == OFF_TXCTL) begin
         tx_wake_flag <= reg_wdata[WAKE_BIT]; // R12
      end else if (tx_load) begin
         tx_wake_flag <= 1'b0; // R11 R15
      end
   end

   // Transmit buffer and its fill state
   always_ff @(posedge clk) begin
      if (!rstn) begin
         tx_data_buffer <= 8'h00;
         tx_full <= 1'b0;
      end else begin
         tx_full <= (tx_full && !tx_load) || (reg_wr && reg_addr == OFF_TXBUF);
         if (reg_wr && reg_addr == OFF_TXBUF) begin
            tx_data_buffer <= reg_wdata[7:0];
         end
      end
   end

   // Read mux, zero for unmapped addresses
   always_ff @(posedge clk) begin
      if (!rstn) begin
         reg_rdata <= 32'h0;
      end else begin
         reg_rdata <= 32'h0;
         if (reg_rd) begin
            unique case (reg_addr)
               OFF_COMM: reg_rdata <= {24'h0, comm_control_reg};
               OFF_TXCTL: reg_rdata <= {28'h0, tx_action_enable, !tx_full, tx_wake_flag, 1'b0};
               OFF_RXCTL: reg_rdata <= {28'h0, sleep_en, rx_ready, rx_wake_flag, 1'b0}; // R20
               OFF_RXBUF: reg_rdata <= {24'h0, rx_data_buffer};
               default: reg_rdata <= 32'h0;
            endcase
         end
      end
   end

   // ------------------------------------------------
   // Transmitter
   // ------------------------------------------------
   assign tx_load = (tx_state == UAMP_IDLE) && tx_full;
   assign tx_request = tx_load && tx_action_enable; // R16

   // Shift engine, independent of the receiver
   always_ff @(posedge clk) begin // R18
      if (!rstn) begin
         tx_state <= UAMP_IDLE;
         tx_shift_register <= '1;
         tx_bits <= 4'h0;
         tx_sub <= 3'h0;
         tx_line <= 1'b1;
      end else if (tx_load) begin
         tx_state <= UAMP_BUSY;
         tx_sub <= 3'h0;
         if (!am && tx_wake_flag) begin
            tx_shift_register <= '1; // R13
            tx_bits <= IDLE_GAP_BITS;
         end else begin
            tx_shift_register <= uamp_frame(tx_data_buffer, lm1, pe, po, am, tx_wake_flag); // R5 R9 R10
            tx_bits <= uamp_flen(lm1, pe, am, ts);
         end
      end else if (tx_state == UAMP_BUSY && rise_tick) begin // R1
         if (tx_sub == 3'h0) begin
            if (tx_bits == 4'h0) begin
               tx_state <= UAMP_IDLE;
            end else begin
               tx_line <= tx_shift_register[0];
               tx_shift_register <= {1'b1, tx_shift_register[FRAME_W-1:1]};
               tx_bits <= tx_bits - 4'h1;
            end
         end
         tx_sub <= iso ? 3'h0 : tx_sub + 3'h1; // R4 R3
      end
   end
   assign link.serial_tx_line = tx_line;

   // ------------------------------------------------
   // Receiver
   // ------------------------------------------------
   // Two-stage synchroniser for the incoming line
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rx_s1 <= 1'b1;
         rx_s2 <= 1'b1;
      end else begin
         rx_s1 <= link.serial_rx_line;
         rx_s2 <= rx_s1;
      end
   end

   assign bit_end = iso || rx_sub == SUB_LAST; // R4
   assign rx_val = iso ? rx_s2 : (vote[0] & vote[1]) | (vote[0] & vote[2]) | (vote[1] & vote[2]);
   assign rx_abort = !iso && rx_idx == 4'h0 && rx_sub <= START_CHK_LAST && rx_s2;
   assign rx_done = rx_state == UAMP_BUSY && fall_tick && !rx_abort && bit_end
                    && rx_idx == uamp_flen(lm1, pe, am, 1'b0) - 4'h1;
   assign rx_is_addr = am ? rx_shift_register[4'(lm1) + 4'h2] : gap_ok; // R7 R9
   assign rx_deliver = rx_done && (!sleep_en || rx_is_addr); // R21
   assign rx_request = rx_deliver;

   // Idle-bit counter, saturating, latched at each start bit
   always_ff @(posedge clk) begin // R22
      if (!rstn) begin
         idle_bits <= 4'h0;
         idle_sub <= 3'h0;
         gap_ok <= 1'b0;
      end else if (fall_tick && rx_state == UAMP_IDLE) begin
         if (rx_s2) begin // R6
            idle_sub <= iso ? 3'h0 : idle_sub + 3'h1;
            if ((iso || idle_sub == SUB_LAST) && idle_bits != IDLE_ADDR_MIN) begin
               idle_bits <= idle_bits + 4'h1;
            end
         end else begin
            gap_ok <= idle_bits >= IDLE_ADDR_MIN; // R7
            idle_bits <= 4'h0;
            idle_sub <= 3'h0;
         end
      end
   end

   // Frame sampler on falling baud edges
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rx_state <= UAMP_IDLE;
         rx_shift_register <= '1;
         rx_idx <= 4'h0;
         rx_sub <= 3'h0;
         vote <= 3'h0;
      end else if (fall_tick) begin // R1
         if (rx_state == UAMP_IDLE) begin
            if (!rx_s2) begin
               rx_state <= UAMP_BUSY;
               rx_shift_register <= '1;
               rx_shift_register[0] <= 1'b0;
               rx_idx <= iso ? 4'h1 : 4'h0;
               rx_sub <= 3'h1;
            end
         end else if (rx_abort) begin
            rx_state <= UAMP_IDLE; // Noise, not a start bit
         end else begin
            if (!iso && rx_sub >= VOTE_FIRST && rx_sub <= VOTE_LAST) begin
               vote[2'(rx_sub - VOTE_FIRST)] <= rx_s2;
            end
            if (bit_end) begin
               rx_shift_register[rx_idx] <= rx_val;
               rx_idx <= rx_idx + 4'h1;
               if (rx_done) begin
                  rx_state <= UAMP_IDLE;
               end
            end
            rx_sub <= rx_sub + 3'h1;
         end
      end
   end

   // Receive buffer, wake and ready; a new frame beats the read clear
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rx_data_buffer <= 8'h00;
         rx_wake_flag <= 1'b0;
         rx_ready <= 1'b0;
      end else if (rx_deliver) begin
         rx_data_buffer <= uamp_rx_data(rx_shift_register, lm1);
         rx_wake_flag <= rx_is_addr; // R20 R8
         rx_ready <= 1'b1;
      end else if (reg_rd && reg_addr == OFF_RXBUF) begin
         rx_ready <= 1'b0;
      end
   end
endmodule

/* design/uamp_link_if.sv */
// Serial link between the device and a peer: baud clock and two data lines.
// Assumes the device makes the baud clock; lines idle high.
`timescale 1ns/10ps
interface uamp_link_if;
   logic baud_clk; // Baud clock made by the device
   logic serial_tx_line; // Device to peer
   logic serial_rx_line; // Peer to device
   modport dev(output baud_clk, output serial_tx_line, input serial_rx_line);
   modport peer(input baud_clk, input serial_tx_line, output serial_rx_line);
endinterface

/* design/uamp_peer.sv */
// Peer end: another serial node that sends and receives frames on the shared link.
// Assumes the device makes the baud clock; clock and line are synchronised here.
`timescale 1ns/10ps
module uamp_peer (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Serial link
   uamp_link_if.peer link,
   // Frame configuration, same meaning as the device fields
   input wire logic [2:0] cfg_len_m1,
   input wire logic cfg_addr_mode,
   input wire logic cfg_iso,
   input wire logic cfg_par_en,
   input wire logic cfg_par_odd,
   input wire logic cfg_two_stop,
   // Send side
   input wire logic send_valid,
   input wire logic [7:0] send_data,
   input wire logic send_addr,
   output logic send_ready,
   // Receive side
   output logic recv_valid,
   output logic [7:0] recv_data,
   output logic recv_addr
);
   import uamp_pkg::*;

   // ------------------------------------------------
   // Declarations
   // ------------------------------------------------
   logic [2:0] clk_s; // Baud clock synchroniser and edge stage
   logic [1:0] line_s; // Line synchroniser
   logic rise_tick, fall_tick;
   uamp_state_type tx_state, rx_state;
   logic [FRAME_W+10:0] tx_vec; // Optional gap, then frame
   logic [4:0] tx_bits;
   logic [2:0] tx_sub, rx_sub, idle_sub;
   logic tx_line, mid, gap_ok, bit_end, rx_done;
   logic [FRAME_W-1:0] rx_vec;
   logic [3:0] rx_idx, idle_bits;

   // ------------------------------------------------
   // Baud edges
   // ------------------------------------------------
   // Edges found past the synchroniser only
   always_ff @(posedge clk) begin
      if (!rstn) begin
         clk_s <= 3'h0;
         line_s <= 2'h3;
      end else begin
         clk_s <= {clk_s[1:0], link.baud_clk};
         line_s <= {line_s[0], link.serial_tx_line};
      end
   end
   assign rise_tick = clk_s[1] && !clk_s[2];
   assign fall_tick = !clk_s[1] && clk_s[2];

   // ------------------------------------------------
   // Transmitter
   // ------------------------------------------------
   assign send_ready = tx_state == UAMP_IDLE;

   // Address in idle-line mode goes out behind an idle period
   always_ff @(posedge clk) begin // R17
      if (!rstn) begin
         tx_state <= UAMP_IDLE;
         tx_vec <= '1;
         tx_bits <= 5'h0;
         tx_sub <= 3'h0;
         tx_line <= 1'b1;
      end else if (send_valid && send_ready) begin
         tx_state <= UAMP_BUSY;
         tx_sub <= 3'h0;
         tx_vec <= {uamp_frame(send_data, cfg_len_m1, cfg_par_en, cfg_par_odd, cfg_addr_mode, send_addr),
                    11'h7FF};
         if (!cfg_addr_mode && send_addr) begin
            tx_bits <= 5'(uamp_flen(cfg_len_m1, cfg_par_en, cfg_addr_mode, cfg_two_stop)) + 5'(IDLE_GAP_BITS);
         end else begin
            tx_vec <= {11'h7FF, uamp_frame(send_data, cfg_len_m1, cfg_par_en, cfg_par_odd, cfg_addr_mode,
                                           send_addr)};
            tx_bits <= 5'(uamp_flen(cfg_len_m1, cfg_par_en, cfg_addr_mode, cfg_two_stop));
         end
      end else if (tx_state == UAMP_BUSY && rise_tick) begin // R1
         if (tx_sub == 3'h0) begin
            if (tx_bits == 5'h0) begin
               tx_state <= UAMP_IDLE;
            end else begin
               tx_line <= tx_vec[0];
               tx_vec <= {1'b1, tx_vec[FRAME_W+10:1]};
               tx_bits <= tx_bits - 5'h1;
            end
         end
         tx_sub <= cfg_iso ? 3'h0 : tx_sub + 3'h1; // R4
      end
   end
   assign link.serial_rx_line = tx_line; // R19

   // ------------------------------------------------
   // Receiver
   // ------------------------------------------------
   assign bit_end = cfg_iso || rx_sub == SUB_LAST;
   assign rx_done = rx_state == UAMP_BUSY && fall_tick && bit_end
                    && rx_idx == uamp_flen(cfg_len_m1, cfg_par_en, cfg_addr_mode, 1'b0) - 4'h1;

   // Idle counting for idle-line addressing
   always_ff @(posedge clk) begin
      if (!rstn) begin
         idle_bits <= 4'h0;
         idle_sub <= 3'h0;
         gap_ok <= 1'b0;
      end else if (fall_tick && rx_state == UAMP_IDLE) begin
         if (line_s[1]) begin
            idle_sub <= cfg_iso ? 3'h0 : idle_sub + 3'h1;
            if ((cfg_iso || idle_sub == SUB_LAST) && idle_bits != IDLE_ADDR_MIN) begin
               idle_bits <= idle_bits + 4'h1;
            end
         end else begin
            gap_ok <= idle_bits >= IDLE_ADDR_MIN;
            idle_bits <= 4'h0;
            idle_sub <= 3'h0;
         end
      end
   end

   // Single mid-bit sample per bit
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rx_state <= UAMP_IDLE;
         rx_vec <= '1;
         rx_idx <= 4'h0;
         rx_sub <= 3'h0;
         mid <= 1'b1;
      end else if (fall_tick) begin
         if (rx_state == UAMP_IDLE) begin
            if (!line_s[1]) begin
               rx_state <= UAMP_BUSY;
               rx_vec[0] <= 1'b0;
               rx_idx <= cfg_iso ? 4'h1 : 4'h0;
               rx_sub <= 3'h1;
            end
         end else begin
            if (rx_sub == SAMPLE_MID) begin
               mid <= line_s[1];
            end
            if (bit_end) begin
               rx_vec[rx_idx] <= cfg_iso ? line_s[1] : mid;
               rx_idx <= rx_idx + 4'h1;
               if (rx_done) begin
                  rx_state <= UAMP_IDLE;
               end
            end
            rx_sub <= rx_sub + 3'h1;
         end
      end
   end

   // Received frame handed to the user
   always_ff @(posedge clk) begin
      if (!rstn) begin
         recv_valid <= 1'b0;
         recv_data <= 8'h00;
         recv_addr <= 1'b0;
      end else begin
         recv_valid <= rx_done;
         if (rx_done) begin
            recv_data <= uamp_rx_data(rx_vec, cfg_len_m1);
            recv_addr <= cfg_addr_mode ? rx_vec[4'(cfg_len_m1) + 4'h2] : gap_ok;
         end
      end
   end
endmodule

/* design/uamp_pkg.sv */
// Shared constants, frame helpers and the register map of the multiprocessor serial link.
// Assumes both ends are compiled against this package before the interface and modules.
//
// Functional notes
// R1: Receive on falling, transmit on rising baud edge
// R2: Mode bit selects idle-line 0, address-bit 1
// R3: Both modes work with either timing
// R4: Bit is 8 baud periods async, 1 iso
// R5: Frame: start, 1-8 data, options, stop
// R6: Idle bit is high period between frames
// R7: Ten or more idle bits mark address
// R8: Each address frame starts a new block
// R9: Address-bit mode: extra bit after data
// R10: Transmitter sends wake flag as address bit
// R11: Wake flag cleared when buffer moves to shifter
// R12: First write after wake set is address
// R13: Idle-line wake write sends idle gap instead
// R14: Software sets wake, dummy-writes, waits, writes address
// R15: Wake cleared same cycle ready flag sets
// R16: Action enable raises transmit request on move
// R17: Software keeps gaps long before addresses only
// R18: Transmitter and receiver run concurrently
// R19: Only one device drives a line
// R20: Receive wake flag shows buffered frame kind
// R21: Sleep passes only address frames to buffer
// R22: Saturating idle counter latched at start bit
package uamp_pkg;
   // ------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------
   localparam int ADDR_W = 5;
   localparam logic [4:0] OFF_COMM = 5'h00; // comm_control_reg
   localparam logic [4:0] OFF_TXCTL = 5'h04; // tx_control_reg
   localparam logic [4:0] OFF_RXCTL = 5'h08; // rx_control_reg
   localparam logic [4:0] OFF_TXBUF = 5'h0C; // tx_data_buffer
   localparam logic [4:0] OFF_RXBUF = 5'h10; // rx_data_buffer
   // comm_control_reg fields
   localparam int CCR_LEN_LSB = 0; // data length minus one, 3 bits
   localparam int CCR_ADDR_MODE = 3; // 0 idle-line, 1 address-bit
   localparam int CCR_ISO = 4; // 1 isosynchronous timing
   localparam int CCR_PAR_EN = 5; // parity bit present
   localparam int CCR_PAR_ODD = 6; // odd parity
   localparam int CCR_TWO_STOP = 7; // second stop bit
   localparam logic [7:0] CCR_RST = 8'h07; // 8 data bits, idle-line, async
   // control register fields
   localparam int WAKE_BIT = 1; // tx_wake_flag / rx_wake_flag
   localparam int READY_BIT = 2; // tx_ready_flag / receive ready
   localparam int ENA_BIT = 3; // tx_action_enable / sleep enable
   // ------------------------------------------------
   // Timing
   // ------------------------------------------------
   localparam int BAUD_HALF_DEF = 4; // clk cycles per half baud period
   localparam int FRAME_W = 13; // longest frame
   localparam logic [2:0] SUB_LAST = 3'h7; // last of 8 baud periods per bit
   localparam logic [2:0] START_CHK_LAST = 3'h3; // first four samples low
   localparam logic [2:0] VOTE_FIRST = 3'h3; // 4th, 5th, 6th samples vote
   localparam logic [2:0] VOTE_LAST = 3'h5;
   localparam logic [2:0] SAMPLE_MID = 3'h4; // single mid sample at the peer
   localparam logic [3:0] IDLE_ADDR_MIN = 4'hA; // idle bits that mark an address
   localparam logic [3:0] IDLE_GAP_BITS = 4'hB; // idle period sent on a wake write

   typedef enum logic [1:0] {UAMP_IDLE = 2'b01, UAMP_BUSY = 2'b10} uamp_state_type;

   // Frame length in bits including start and stop bits
   function automatic logic [3:0] uamp_flen(input logic [2:0] lm1, input logic pe, input logic am,
                                            input logic ts);
      uamp_flen = 4'(lm1) + 4'h3 + 4'(pe) + 4'(am) + 4'(ts);
   endfunction

   // Frame bits, LSB first: start, data, address, parity, stops
   function automatic logic [FRAME_W-1:0] uamp_frame(input logic [7:0] d, input logic [2:0] lm1,
                                                     input logic pe, input logic po,
                                                     input logic am, input logic ab);
      logic [FRAME_W-1:0] v;
      logic p;
      int k;
      v = '1;
      v[0] = 1'b0;
      p = po;
      for (int i = 0; i < 8; i++) begin
         if (i <= int'(lm1)) begin
            v[i+1] = d[i];
            p = p ^ d[i];
         end
      end
      k = int'(lm1) + 2;
      if (am) begin
         v[k] = ab;
         p = p ^ ab;
         k = k + 1;
      end
      if (pe) begin
         v[k] = p;
      end
      uamp_frame = v;
   endfunction

   // Data field of a received frame
   function automatic logic [7:0] uamp_rx_data(input logic [FRAME_W-1:0] v, input logic [2:0] lm1);
      logic [7:0] d;
      d = 8'h00;
      for (int i = 0; i < 8; i++) begin
         if (i <= int'(lm1)) begin
            d[i] = v[i+1];
         end
      end
      uamp_rx_data = d;
   endfunction
endpackage

/* dv/tb_top.sv */
// Self-checking bench: device and peer joined by the link, user sides driven here.
// Assumes the package, interface and both ends are compiled first.
`timescale 1ns/10ps
module tb_top;
   import uamp_pkg::*;
   logic clk = 0, rstn = 0, rwr = 0, rrd = 0, rdp = 0, txq, rxq, md = 0, iso = 0, psv = 0, psa = 0, sr, rv, radr;
   logic pen = 0, pod = 0, tst = 0; // Random parity and stop options
   logic [4:0] ra = '0;
   logic [31:0] wd = '0, rdata;
   logic [7:0] psd = '0, rdt;
   logic [31:0] rq[$]; // Expected read data
   logic [8:0] pq[$]; // Expected peer frames
   int err_total = 0, n_tests = 0, txn = 0, rxn = 0, cyc = 0;
   uamp_link_if link();
   uamp_device #(.BAUD_HALF(2)) i_uamp_device(.clk(clk), .rstn(rstn), .link(link), .reg_addr(ra),
      .reg_wdata(wd), .reg_wr(rwr), .reg_rd(rrd), .reg_rdata(rdata), .tx_request(txq), .rx_request(rxq));
   uamp_peer i_uamp_peer(.clk(clk), .rstn(rstn), .link(link), .cfg_len_m1(3'h7), .cfg_addr_mode(md),
      .cfg_iso(iso), .cfg_par_en(pen), .cfg_par_odd(pod), .cfg_two_stop(tst), .send_valid(psv),
      .send_data(psd), .send_addr(psa), .send_ready(sr), .recv_valid(rv), .recv_data(rdt), .recv_addr(radr));
   uamp_link_sva #(.BH(2)) i_uamp_link_sva(.clk(clk), .rstn(rstn), .baud_clk(link.baud_clk),
      .serial_tx_line(link.serial_tx_line), .serial_rx_line(link.serial_rx_line));
   always #12.5 clk = ~clk;
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      n_tests++;
      if (s !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task conclude;
      $display("Counts: %0d checks, %0d mismatches", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task wr(input logic [4:0] a, input logic [31:0] d);
      ra <= a;
      wd <= d;
      rwr <= 1'b1;
      @(posedge clk);
      rwr <= 1'b0;
      @(posedge clk);
   endtask
   task rd(input logic [4:0] a, input logic [31:0] e);
      rq.push_back(e);
      ra <= a;
      rrd <= 1'b1;
      @(posedge clk);
      rrd <= 1'b0;
      @(posedge clk);
   endtask
   task psend(input logic [7:0] d, input logic a);
      psd <= d;
      psa <= a;
      psv <= 1'b1;
      do @(negedge clk); while (sr !== 1'b1);
      @(posedge clk);
      psv <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wcnt(ref int c, input int n);
      for (int i = 0; i < 6000 && c < n; i++) @(posedge clk);
   endtask
   // Count request pulses where settled
   always @(negedge clk) begin
      if (txq === 1'b1) txn++;
      if (rxq === 1'b1) rxn++;
   end
   // Result watcher and hang limit
   always @(posedge clk) begin
      rdp <= rrd;
      cyc <= cyc + 1;
      if (rdp) chk("reg_rdata", rq.pop_front(), rdata);
      if (rv === 1'b1) chk("peer_frame", 32'(pq.pop_front()), 32'({radr, rdt}));
      if (cyc > 60000) begin
         err_total++;
         conclude;
      end
   end
   initial begin
      logic [7:0] a, d;
      int t0, r0;
      logic [2:0] opt; // Random frame options
      void'($urandom(32'h607d));
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      rd(OFF_COMM, 32'h7);
      rd(OFF_TXCTL, 32'h4);
      rd(5'h14, 32'h0);
      $display("test reset done");
      for (int k = 0; k < 4; k++) begin
         md <= k[0];
         iso <= k[1];
         a = 8'($urandom);
         d = 8'($urandom);
         opt = 3'($urandom);
         {tst, pod, pen} <= opt;
         wr(OFF_COMM, {24'h0, opt, k[1], k[0], 3'h7});
         wr(OFF_RXCTL, 32'h8);
         r0 = rxn;
         fork
            begin
               t0 = txn;
               pq.push_back({1'b1, a});
               pq.push_back({1'b0, d});
               wr(OFF_TXCTL, 32'hA);
               if (k[0] == 1'b0) begin
                  wr(OFF_TXBUF, 32'(~a));
                  wcnt(txn, t0 + 1);
               end
               wr(OFF_TXBUF, 32'(a));
               wcnt(txn, t0 + 2 - k[0]);
               rd(OFF_TXCTL, 32'hC);
               wr(OFF_TXBUF, 32'(d));
            end
            begin
               psend(d, 1'b1);
               psend(a, 1'b0);
            end
         join
         for (int i = 0; i < 3000 && (pq.size() != 0 || sr !== 1'b1); i++) @(posedge clk);
         repeat (400) @(posedge clk); // Quiet line longer than ten bits
         chk("rx_count", r0 + 1, rxn);
         rd(OFF_RXCTL, 32'hE);
         rd(OFF_RXBUF, 32'(d));
         wr(OFF_RXCTL, 32'h0);
         psend(a, 1'b0);
         wcnt(rxn, r0 + 2);
         rd(OFF_RXCTL, k[0] ? 32'h4 : 32'h6);
         rd(OFF_RXBUF, 32'(a));
         $display("test %0d done", k);
      end
      conclude;
   end
endmodule

/* dv/uamp_link_sva.sv */
// Checker for the link wires between device end and peer end.
// Assumes clk samples the link and the device makes baud_clk.
`timescale 1ns/10ps
module uamp_link_sva #(
   parameter int BH = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Link wires
   input wire logic baud_clk,
   input wire logic serial_tx_line,
   input wire logic serial_rx_line
);
   bit b_q, t_q, r_q; // Previous samples
   int hc, tc, rc; // Samples held at current level
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // Age of each wire level
   always_ff @(posedge clk) begin
      b_q <= baud_clk;
      t_q <= serial_tx_line;
      r_q <= serial_rx_line;
      hc <= (baud_clk != b_q) ? 1 : hc + 1;
      tc <= (serial_tx_line != t_q) ? 1 : tc + 1;
      rc <= (serial_rx_line != r_q) ? 1 : rc + 1;
   end
   property p_tx_edge; $changed(serial_tx_line) |-> $rose(baud_clk); endproperty
   a_tx_edge: assert property (p_tx_edge) else $error("tx moved off a baud rise");
   property p_baud_hi; $fell(baud_clk) |-> hc == BH; endproperty
   a_baud_hi: assert property (p_baud_hi) else $error("baud high phase wrong");
   property p_baud_lo; $rose(baud_clk) |-> hc >= BH; endproperty
   a_baud_lo: assert property (p_baud_lo) else $error("baud low phase short");
   property p_idle; $rose(rstn) |-> serial_tx_line && serial_rx_line; endproperty
   a_idle: assert property (p_idle) else $error("line not idle high after reset");
   property p_tx_low; $fell(serial_tx_line) |-> ##[1:400] serial_tx_line; endproperty
   a_tx_low: assert property (p_tx_low) else $error("tx frame lacks stop bit");
   property p_rx_low; $fell(serial_rx_line) |-> ##[1:400] serial_rx_line; endproperty
   a_rx_low: assert property (p_rx_low) else $error("rx frame lacks stop bit");
   property p_tx_space; $changed(serial_tx_line) |-> tc >= 2 * BH; endproperty
   a_tx_space: assert property (p_tx_space) else $error("tx bit shorter than a baud period");
   property p_rx_space; $changed(serial_rx_line) |-> rc >= 2 * BH; endproperty
   a_rx_space: assert property (p_rx_space) else $error("rx bit shorter than a baud period");
   c_tx_start: cover property ($fell(serial_tx_line));
   c_rx_start: cover property ($fell(serial_rx_line));
   c_duplex: cover property (!serial_tx_line && !serial_rx_line);
endmodule
